//--- quad_counter_byte_readout.v
// How it works
// [R1] Select 0 gives high byte, 1 low
// [R2] Select also steers the latch inhibit
// [R3] Pulse on every decoded state transition
// [R4] Direction high counting up, low down
// [R5] Direction settles before each pulse rises
// [R6] Cascade pulse on counter overflow or underflow
// [R7] External counter clocks on cascade rising edge
// [R8] Latch read as two bytes on port
// [R9] Host reads high byte first, then low
// [R10] New count visible after rising edge
// [R11] Pulses rise on rising, fall on falling
// [R12] Pulses return low only on falling edge
// [R13] Direction changes only on rising edge
// [R14] Port driven while enable low, else released
// [R15] Select and enable sampled on falling edge
// [R16] Reset low clears counter, latch, inhibit
// [R17] Latch captures each edge unless inhibited
// [R18] Count pulse half cycle, ignores inhibit
// [R19] Inhibit on high read, released after low
// [R20] Cascade pulse in the wrapping update cycle
`timescale 1ns/1ps
`default_nettype none
`include "quad_counter_map.vh"

module quad_counter_byte_readout
(
	input  wire                   ref_clk,
	input  wire                   sys_rst,
	input  wire                   pos_rst_n,
	input  wire                   enc_a,
	input  wire                   enc_b,
	input  wire                   sel_low,
	input  wire                   out_en_n,
	output wire [`BYTE_WIDTH-1:0] byte_out_port,
	output wire                   byte_out_oe_n,
	output wire                   decode_count_pulse,
	output wire                   wrap_carry_pulse,
	output wire                   count_up
);

	// ------------------------------------------------------------------
	// Inhibit states
	// ------------------------------------------------------------------
	localparam [2:0] ST_TRACK   = 3'b001;
	localparam [2:0] ST_HOLD    = 3'b010;
	localparam [2:0] ST_LOWREAD = 3'b100;

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	wire                   step_evt;
	wire                   step_up;
	reg                    evt_d_r;
	reg                    up_r;
	reg  [`POS_WIDTH-1:0]  pos_cnt_r;
	reg  [`POS_WIDTH-1:0]  pos_cnt_nxt;
	reg                    wrap_nxt;
	reg  [`POS_WIDTH-1:0]  latch_r;
	reg  [`POS_WIDTH-1:0]  latch_nxt;
	reg                    dec_tgl_r;
	reg                    dec_fall_r;
	reg                    cas_tgl_r;
	reg                    cas_fall_r;
	reg  [`SYNC_DEPTH-1:0] sel_sync_r;
	reg  [`SYNC_DEPTH-1:0] oe_sync_r;
	reg                    sel_f_r;
	reg                    oe_n_f_r;
	reg  [2:0]             inh_state_r;
	reg  [2:0]             inh_state_nxt;
	wire                   inhibit;
	reg  [`BYTE_WIDTH-1:0] byte_out_r;
	reg                    byte_oe_n_r;

	// ------------------------------------------------------------------
	// Quadrature decoding
	// ------------------------------------------------------------------
	quad_decode u_decode
	(
		.ref_clk  (ref_clk),
		.sys_rst  (sys_rst),
		.enc_a    (enc_a),
		.enc_b    (enc_b),
		.step_evt (step_evt),
		.step_up  (step_up)
	);

	// ------------------------------------------------------------------
	// Direction and counter update
	// ------------------------------------------------------------------
	// Direction is taken one cycle ahead of the counter update, so it is
	// already stable when the count and cascade pulses rise.
	always @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			evt_d_r <= 1'b0;
			up_r    <= 1'b0;
		end
		else
		begin
			evt_d_r <= step_evt;
			if (step_evt)
				up_r <= step_up;                           // [R4] [R5] [R13]
		end
	end

	always @*
	begin
		pos_cnt_nxt = pos_cnt_r;
		wrap_nxt    = 1'b0;
		if (evt_d_r)
		begin
			if (up_r)
			begin
				pos_cnt_nxt = pos_cnt_r + 16'h0001;
				wrap_nxt    = (pos_cnt_r == `POS_ALL_ONES);       // [R6] [R20]
			end
			else
			begin
				pos_cnt_nxt = pos_cnt_r - 16'h0001;
				wrap_nxt    = (pos_cnt_r == `POS_RESET);          // [R6] [R20]
			end
		end
	end

	always @*
	begin
		if (inhibit)
			latch_nxt = latch_r;
		else
			latch_nxt = pos_cnt_nxt;                            // [R17]
	end

	// The reset pin clears at once without waiting for the clock.
	always @(posedge ref_clk or negedge pos_rst_n)
	begin
		if (!pos_rst_n)
		begin
			pos_cnt_r <= `POS_RESET;                              // [R16]
			latch_r   <= `POS_RESET;                              // [R16]
		end
		else if (sys_rst)
		begin
			pos_cnt_r <= `POS_RESET;
			latch_r   <= `POS_RESET;
		end
		else
		begin
			pos_cnt_r <= pos_cnt_nxt;
			latch_r   <= latch_nxt;                               // [R10] [R17]
		end
	end

	// ------------------------------------------------------------------
	// Half-cycle pulses
	// ------------------------------------------------------------------
	// Each event flips a rising-edge toggle; a falling-edge copy closes
	// the pulse, so back-to-back events still give separate pulses.
	always @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			dec_tgl_r <= 1'b0;
			cas_tgl_r <= 1'b0;
		end
		else
		begin
			if (evt_d_r)
				dec_tgl_r <= ~dec_tgl_r;                        // [R18] [R11]
			if (wrap_nxt)
				cas_tgl_r <= ~cas_tgl_r;                        // [R6] [R11]
		end
	end

	always @(negedge ref_clk)
	begin
		if (sys_rst)
		begin
			dec_fall_r <= 1'b0;
			cas_fall_r <= 1'b0;
		end
		else
		begin
			dec_fall_r <= dec_tgl_r;                            // [R12]
			cas_fall_r <= cas_tgl_r;                            // [R12]
		end
	end

	// ------------------------------------------------------------------
	// Host strobe sampling
	// ------------------------------------------------------------------
	// Strobes are sampled on the falling edge; a new level counts only
	// when the last two stages agree, which costs four cycles of latency.
	always @(negedge ref_clk)
	begin
		if (sys_rst)
		begin
			sel_sync_r <= {`SYNC_DEPTH{1'b0}};
			oe_sync_r  <= {`SYNC_DEPTH{1'b1}};
		end
		else
		begin
			sel_sync_r <= {sel_sync_r[`SYNC_DEPTH-2:0], sel_low};   // [R15]
			oe_sync_r  <= {oe_sync_r[`SYNC_DEPTH-2:0], out_en_n};   // [R15]
		end
	end

	always @(negedge ref_clk or negedge pos_rst_n)
	begin
		if (!pos_rst_n)
		begin
			sel_f_r     <= `SEL_HIGH_BYTE;
			oe_n_f_r    <= 1'b1;
			inh_state_r <= ST_TRACK;                              // [R16]
		end
		else if (sys_rst)
		begin
			sel_f_r     <= `SEL_HIGH_BYTE;
			oe_n_f_r    <= 1'b1;
			inh_state_r <= ST_TRACK;
		end
		else
		begin
			if (sel_sync_r[1] == sel_sync_r[2])
				sel_f_r <= sel_sync_r[2];
			if (oe_sync_r[1] == oe_sync_r[2])
				oe_n_f_r <= oe_sync_r[2];
			inh_state_r <= inh_state_nxt;
		end
	end

	// ------------------------------------------------------------------
	// Inhibit sequencer
	// ------------------------------------------------------------------
	// A low-byte read without a prior high-byte read does not freeze the
	// latch; the host is expected to read high first.
	always @*
	begin
		inh_state_nxt = inh_state_r;
		case (inh_state_r)
			ST_TRACK:
			begin
				if (!oe_n_f_r && sel_f_r == `SEL_HIGH_BYTE)
					inh_state_nxt = ST_HOLD;                    // [R2] [R19] [R9]
			end
			ST_HOLD:
			begin
				if (!oe_n_f_r && sel_f_r == `SEL_LOW_BYTE)
					inh_state_nxt = ST_LOWREAD;                 // [R2] [R19]
			end
			ST_LOWREAD:
			begin
				if (oe_n_f_r)
					inh_state_nxt = ST_TRACK;                   // [R19] [R17]
			end
			default:
			begin
				inh_state_nxt = ST_TRACK;
			end
		endcase
	end

	assign inhibit = (inh_state_r != ST_TRACK);

	// ------------------------------------------------------------------
	// Byte port
	// ------------------------------------------------------------------
	always @(posedge ref_clk or negedge pos_rst_n)
	begin
		if (!pos_rst_n)
		begin
			byte_out_r  <= `BYTE_RESET;
			byte_oe_n_r <= 1'b1;
		end
		else if (sys_rst)
		begin
			byte_out_r  <= `BYTE_RESET;
			byte_oe_n_r <= 1'b1;
		end
		else
		begin
			if (sel_f_r == `SEL_LOW_BYTE)
				byte_out_r <= latch_nxt[`LOW_BYTE_MSB:`LOW_BYTE_LSB];   // [R1] [R8]
			else
				byte_out_r <= latch_nxt[`HIGH_BYTE_MSB:`HIGH_BYTE_LSB]; // [R1] [R8]
			byte_oe_n_r <= oe_n_f_r;                            // [R14]
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign byte_out_port      = byte_out_r;
	assign byte_out_oe_n      = byte_oe_n_r;                     // [R14]
	assign count_up           = up_r;                            // [R4]
	// Pulse rises on the rising edge and ends on the next falling edge
	assign decode_count_pulse = dec_tgl_r ^ dec_fall_r;          // [R11] [R18]
	// Rising edge may clock an external counter using count_up
	assign wrap_carry_pulse   = cas_tgl_r ^ cas_fall_r;          // [R7] [R11]

endmodule

`default_nettype wire

//--- quad_counter_map.vh
`ifndef QUAD_COUNTER_MAP_VH
`define QUAD_COUNTER_MAP_VH

// ----------------------------------------------------------------------
// Widths and field positions
// ----------------------------------------------------------------------
`define POS_WIDTH      16
`define BYTE_WIDTH     8
`define HIGH_BYTE_MSB  15
`define HIGH_BYTE_LSB  8
`define LOW_BYTE_MSB   7
`define LOW_BYTE_LSB   0
`define SYNC_DEPTH     3

// ----------------------------------------------------------------------
// Reset values and encodings
// ----------------------------------------------------------------------
`define POS_RESET      16'h0000
`define POS_ALL_ONES   16'hffff
`define BYTE_RESET     8'h00
`define SEL_HIGH_BYTE  1'b0
`define SEL_LOW_BYTE   1'b1

`endif

//--- quad_decode.v
`timescale 1ns/1ps
`default_nettype none
`include "quad_counter_map.vh"

module quad_decode
(
	input  wire       ref_clk,
	input  wire       sys_rst,
	input  wire       enc_a,
	input  wire       enc_b,
	output reg        step_evt,
	output reg        step_up
);

	// ------------------------------------------------------------------
	// Channel synchronisers
	// ------------------------------------------------------------------
	wire [1:0] enc_pin;
	reg  [1:0] filt_r;
	reg  [1:0] prev_r;
	wire [1:0] stage2;
	wire [1:0] stage3;

	assign enc_pin = {enc_a, enc_b};

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch = ch + 1)
		begin : g_sync
			reg [`SYNC_DEPTH-1:0] sync_r;
			always @(posedge ref_clk)
			begin
				if (sys_rst)
					sync_r <= {`SYNC_DEPTH{1'b0}};
				else
					sync_r <= {sync_r[`SYNC_DEPTH-2:0], enc_pin[ch]};
			end
			assign stage2[ch] = sync_r[1];
			assign stage3[ch] = sync_r[2];
		end
	endgenerate

	// ------------------------------------------------------------------
	// State compare and direction
	// ------------------------------------------------------------------
	// A level is taken only once two later stages agree, so a metastable
	// first stage never reaches the decoder.
	always @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			filt_r   <= 2'b00;
			prev_r   <= 2'b00;
			step_evt <= 1'b0;
			step_up  <= 1'b0;
		end
		else
		begin
			if (stage2[1] == stage3[1])
				filt_r[1] <= stage3[1];
			if (stage2[0] == stage3[0])
				filt_r[0] <= stage3[0];
			prev_r   <= filt_r;
			step_evt <= (filt_r != prev_r);                 // [R3]
			// A leading B counts up: 10,11,01,00
			step_up  <= ~(prev_r[1] ^ filt_r[0]);
		end
	end

endmodule

`default_nettype wire

//--- quad_readout_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// Port timing checks
// ----------------------------------------------------------------------
module quad_readout_checker
(
	input wire logic       ref_clk,
	input wire logic       sys_rst,
	input wire logic       pos_rst_n,
	input wire logic       sel_low,
	input wire logic       out_en_n,
	input wire logic [7:0] byte_out_port,
	input wire logic       byte_out_oe_n,
	input wire logic       decode_count_pulse,
	input wire logic       wrap_carry_pulse,
	input wire logic       count_up
);
	// Direction as seen in the clock-high phase
	logic dir_fall_r;
	always @(negedge ref_clk)
		dir_fall_r <= count_up;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst || !pos_rst_n);
	chk_count_low_rise: assert property (!decode_count_pulse)
		else $error("count pulse still high at rising edge");
	chk_wrap_low_rise: assert property (!wrap_carry_pulse)
		else $error("cascade pulse still high at rising edge");
	chk_dir_before_pulse: assert property (@(negedge ref_clk)
		decode_count_pulse |-> count_up == $past(count_up))
		else $error("direction moved with the count pulse");
	chk_dir_rise_only: assert property (count_up == dir_fall_r)
		else $error("direction changed on a falling edge");
	chk_wrap_with_step: assert property (@(negedge ref_clk)
		wrap_carry_pulse |-> decode_count_pulse)
		else $error("cascade pulse without a counter update");
	chk_oe_cause: assert property ($fell(byte_out_oe_n) |->
		!$past(out_en_n) && !$past(out_en_n, 2))
		else $error("port driven without a sampled enable");
	chk_oe_release: assert property ($rose(byte_out_oe_n) |->
		$past(out_en_n) && $past(out_en_n, 2))
		else $error("port released while enable low");
	chk_oe_answer: assert property ($fell(out_en_n) |->
		##[1:5] !byte_out_oe_n)
		else $error("port not driven after enable");
	chk_latch_frozen: assert property (!byte_out_oe_n [*4] |->
		$stable(byte_out_port))
		else $error("port byte moved during a read");
	cover property (@(negedge ref_clk) wrap_carry_pulse && !count_up);
	cover property (@(negedge ref_clk) wrap_carry_pulse && count_up);
	cover property ($fell(byte_out_oe_n) && sel_low);
endmodule
bind quad_counter_byte_readout quad_readout_checker quad_readout_checker_inst
(
	.ref_clk, .sys_rst, .pos_rst_n, .sel_low, .out_en_n, .byte_out_port,
	.byte_out_oe_n, .decode_count_pulse, .wrap_carry_pulse, .count_up
);
`default_nettype wire

//--- ext_cascade_counter.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// External range extension counter
// ----------------------------------------------------------------------
module ext_cascade_counter
(
	input  wire logic       sys_rst,
	input  wire logic       wrap_carry_pulse,
	input  wire logic       count_up,
	output var  logic [7:0] ext_count
);
	// No system clock here: a late direction level would miscount
	always @(posedge wrap_carry_pulse or posedge sys_rst)
		if (sys_rst)
			ext_count <= 8'h00;
		else if (count_up)
			ext_count <= ext_count + 8'h01;
		else
			ext_count <= ext_count - 8'h01;
endmodule
`default_nettype wire

//--- tb_quad_counter_byte_readout.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// Random stepping with frozen two-byte reads
// ----------------------------------------------------------------------
module tb_quad_counter_byte_readout;
	logic        ref_clk = 1'b0;
	logic        sys_rst = 1'b0;
	logic        pos_rst_n = 1'b1;
	logic        enc_a = 1'b0;
	logic        enc_b = 1'b0;
	logic        sel_low = 1'b0;
	logic        out_en_n = 1'b1;
	wire  [7:0]  byte_out_port;
	wire         byte_out_oe_n;
	wire         decode_count_pulse;
	wire         wrap_carry_pulse;
	wire         count_up;
	wire  [7:0]  ext_count;
	int          err_total = 0;
	int          cmp_count = 0;
	int          n_dec = 0;
	int          n_wrap = 0;
	int          n_step = 0;
	int          n_wrap_exp = 0;
	logic [15:0] pos_exp = 16'h0000;
	logic [15:0] got;
	logic [15:0] want;
	logic [7:0]  ext_exp = 8'h00;
	logic [1:0]  phase = 2'b00;

	quad_counter_byte_readout quad_counter_byte_readout_inst
	(
		.ref_clk, .sys_rst, .pos_rst_n, .enc_a, .enc_b, .sel_low, .out_en_n,
		.byte_out_port, .byte_out_oe_n, .decode_count_pulse,
		.wrap_carry_pulse, .count_up
	);
	ext_cascade_counter ext_cascade_counter_inst
	(
		.sys_rst, .wrap_carry_pulse, .count_up, .ext_count
	);

	always #10 ref_clk = ~ref_clk;
	always @(negedge ref_clk)
	begin
		if (decode_count_pulse === 1'b1)
			n_dec++;
		if (wrap_carry_pulse === 1'b1)
			n_wrap++;
	end

	task automatic check(input string what, input logic [15:0] exp,
		input logic [15:0] seen);
		cmp_count++;
		if (seen !== exp)
		begin
			err_total++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask

	// Expected position after one encoder step
	function automatic logic [15:0] pos_after(input logic [15:0] pos,
		input bit up);
		pos_after = up ? pos + 16'h0001 : pos - 16'h0001;
	endfunction

	// A step that leaves all ones upward or zero downward wraps
	function automatic bit wraps(input logic [15:0] pos, input bit up);
		wraps = up ? (pos == 16'hffff) : (pos == 16'h0000);
	endfunction

	task automatic step(input bit up);
		if (wraps(pos_exp, up))
		begin
			n_wrap_exp++;
			ext_exp = up ? ext_exp + 8'h01 : ext_exp - 8'h01;
		end
		pos_exp = pos_after(pos_exp, up);
		phase = up ? phase + 2'b01 : phase - 2'b01;
		n_step++;
		enc_a <= phase[1] ^ phase[0];
		enc_b <= phase[1];
		cyc(8);
		check("direction", {15'h0000, up}, {15'h0000, count_up});
	endtask

	// Steps taken between the two byte reads must not reach the port
	task automatic read_pos(input int mid);
		want = pos_exp;
		out_en_n <= 1'b0;
		cyc(6);
		check("drive", 16'h0000, {15'h0000, byte_out_oe_n});
		got[15:8] = byte_out_port;
		out_en_n <= 1'b1;
		repeat (mid) step(1'($urandom_range(0, 1)));
		cyc(5);
		sel_low <= 1'b1;
		cyc(5);
		out_en_n <= 1'b0;
		cyc(6);
		got[7:0] = byte_out_port;
		out_en_n <= 1'b1;
		cyc(6);
		check("release", 16'h0001, {15'h0000, byte_out_oe_n});
		sel_low <= 1'b0;
		cyc(5);
		check("position", want, got);
	endtask

	task automatic end_of_test;
		if (err_total == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial
	begin
		#1_000_000;
		err_total++;
		end_of_test;
	end

	initial
	begin
		void'($urandom(32'hd37b3073));
		// A real rising edge, so the edge-reset far-side counter clears
		sys_rst <= 1'b1;
		cyc(12);
		sys_rst <= 1'b0;
		cyc(2);
		read_pos(0);
		step(0);
		read_pos(0);
		step(1);
		read_pos(2);
		repeat (8)
		begin
			repeat ($urandom_range(1, 5)) step(1'($urandom_range(0, 1)));
			read_pos($urandom_range(0, 3));
		end
		pos_rst_n <= 1'b0;
		cyc(1);
		pos_rst_n <= 1'b1;
		pos_exp = 16'h0000;
		cyc(4);
		read_pos(0);
		step(0);
		read_pos(1);
		check("count pulses", 16'(n_step), 16'(n_dec));
		check("wrap pulses", 16'(n_wrap_exp), 16'(n_wrap));
		check("extension", {8'h00, ext_exp}, {8'h00, ext_count});
		end_of_test;
	end
endmodule
`default_nettype wire
